// ===== core/was_params.svh
// Constants and reset values for the waveform auto-shutdown block
`ifndef WAS_PARAMS_SVH
`define WAS_PARAMS_SVH
`define WAS_NUM_SRC       4
`define WAS_SRC_CMP1      0
`define WAS_SRC_CMP2      1
`define WAS_SRC_LC2       2
`define WAS_SRC_FLT       3
`define WAS_SEL_RST       4'h0
`define WAS_OVR_RST       2'h0
`define WAS_FORCE_RST     1'b0
`define WAS_FLAG_RST      1'b0
`define WAS_WAVE_RST      1'b0
`define WAS_SYNC_STAGES   3
`endif

// ===== core/was_pkg.sv
// Types for the waveform auto-shutdown block
package was_pkg;
	typedef enum logic [1:0] {
		WAS_RUN      = 2'b00,
		WAS_SHUT     = 2'b01,
		WAS_WAIT_RISE = 2'b10
	} was_state_t;
endpackage : was_pkg

// ===== core/was_shutdown.sv
// Auto-shutdown control for the complementary waveform unit outputs
`timescale 1ns/1ps
`default_nettype none
`include "was_params.svh"
// Function
// R01: Force bit set puts unit in shutdown with override output levels.
// R02: Without auto-restart, shutdown lasts while force bit stays set.
// R03: With auto-restart, hardware clears force bit, resumes at input rise.
// R04: Enabled external source active switches outputs to override at once.
// R05: Sources selectable in any mix: comparators, logic cell, fault pin.
// R06: Active source holds shutdown unless auto-shutdown is disabled.
// R07: Source levels and restart edge synchronised before restart logic.
module was_shutdown (
	input  wire logic       ref_clk_i,                  // Generator clock
	input  wire logic       rst_i,                      // Async reset, high
	input  wire logic       shutdown_enable_i,          // Auto-shutdown on
	input  wire logic       auto_restart_i,             // Auto-restart on
	input  wire logic       force_set_i,                // Pulse: set force
	input  wire logic       force_clr_i,                // Pulse: clear force
	input  wire logic [3:0] source_select_i,            // Source enables
	input  wire logic [1:0] override_level_i,           // Override B/A
	input  wire logic       comparator_one_async_out_i, // Comparator one
	input  wire logic       comparator_two_async_out_i, // Comparator two
	input  wire logic       logic_cell_two_out_i,       // Logic cell two
	input  wire logic       fault_pin_input_i,          // Fault pin, high
	input  wire logic       wave_in_i,                  // Generator input
	input  wire logic [1:0] gen_out_i,                  // Normal B/A levels
	output logic [1:0]      wave_out_o,                 // To power stage
	output logic            shutdown_force_bit_o,       // Force bit
	output logic            shutdown_active_o           // Shutdown flag
);
	// Control state
	was_pkg::was_state_t state;
	was_pkg::was_state_t next_state;
	logic                force_bit;
	logic                next_force_bit;

	// Raw and synchronised views of the asynchronous inputs
	logic [3:0]          src_sync;
	logic [3:0]          src_raw;
	logic                wave_sync;
	logic                wave_prev;
	logic                next_wave_prev;
	logic                rise;

	// Decoded conditions
	logic                src_hit_sync;
	logic                src_hit_raw;
	logic                in_shut;
	logic                take_override;

	// Next values of the registered outputs
	logic [1:0]          next_wave_out;
	logic                next_force_out;
	logic                next_active;

	// Selected-source test, used on the raw and the synchronised path
	function automatic logic sel_hit(
		input logic       en,
		input logic [3:0] lvl,
		input logic [3:0] sel
	);
		sel_hit = en && (|(lvl & sel));
	endfunction : sel_hit

	// Gather sources in a fixed bit order
	assign src_raw[`WAS_SRC_CMP1] = comparator_one_async_out_i;
	assign src_raw[`WAS_SRC_CMP2] = comparator_two_async_out_i;
	assign src_raw[`WAS_SRC_LC2]  = logic_cell_two_out_i;
	assign src_raw[`WAS_SRC_FLT]  = fault_pin_input_i;

	// Synchronise each source level and the input wave
	genvar gi;
	generate
		for (gi = 0; gi < `WAS_NUM_SRC; gi++) begin : g_src
			was_sync u_sync (
				.ref_clk_i (ref_clk_i),
				.rst_i     (rst_i),
				.async_i   (src_raw[gi]),
				.level_o   (src_sync[gi])
			); // [R07]
		end
	endgenerate

	was_sync u_wave_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.async_i   (wave_in_i),
		.level_o   (wave_sync)
	); // [R07]

	// Any enabled source; raw path for the output, synced path for state.
	// The raw path is what makes the override fast; the synced path decides
	// when the state machine enters and may let go, so a glitch on a pin can
	// force the outputs for one cycle but never releases them early.
	assign src_hit_raw  = sel_hit(shutdown_enable_i, src_raw,
		source_select_i);                  // [R05] [R04]
	assign src_hit_sync = sel_hit(shutdown_enable_i, src_sync,
		source_select_i);                  // [R05] [R07]

	// Restart edge on the synchronised wave; both flops reset low, so no
	// false edge follows reset while the pin idles low
	assign rise = wave_sync && !wave_prev; // [R03] [R07]

	// Any state other than running keeps the override on
	assign in_shut = (state != was_pkg::WAS_RUN);

	// Force bit and shutdown state.
	// Software and hardware share the force bit: a set pulse wins over a
	// simultaneous clear and over the restart clear, so a fresh request is
	// never lost. Disabling auto-shutdown drops a source-held shutdown at
	// once but leaves a software shutdown in place.
	always_comb begin
		next_force_bit = force_bit;
		next_state     = state;
		if (force_clr_i) begin
			next_force_bit = 1'b0; // [R02]
		end
		// Set beats a simultaneous clear
		if (force_set_i) begin
			next_force_bit = 1'b1; // [R01]
		end
		if (!shutdown_enable_i && !next_force_bit) begin
			// Disabling auto-shutdown is the only way out under a live source
			next_state = was_pkg::WAS_RUN; // [R06]
		end else begin
			case (state)
				was_pkg::WAS_RUN: begin
					if (next_force_bit || src_hit_sync) begin
						next_state = was_pkg::WAS_SHUT; // [R01] [R04]
					end
				end
				was_pkg::WAS_SHUT: begin
					if (src_hit_sync) begin
						next_state = was_pkg::WAS_SHUT; // [R06]
					end else if (auto_restart_i) begin
						next_state = was_pkg::WAS_WAIT_RISE; // [R03]
					end else if (!next_force_bit) begin
						next_state = was_pkg::WAS_RUN; // [R02]
					end
				end
				was_pkg::WAS_WAIT_RISE: begin
					// Auto-restart withdrawn while waiting: back to the
					// software-held shutdown, force bit untouched
					if (src_hit_sync || force_set_i || !auto_restart_i) begin
						next_state = was_pkg::WAS_SHUT; // [R06] [R02]
					end else if (rise) begin
						next_force_bit = 1'b0; // [R03]
						next_state     = was_pkg::WAS_RUN; // [R03]
					end
				end
				default: begin
					// Unused code: fail safe into shutdown
					next_state = was_pkg::WAS_SHUT;
				end
			endcase
		end
	end

	// Register state and force bit
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state     <= was_pkg::WAS_RUN;
			force_bit <= `WAS_FORCE_RST;
		end else begin
			state     <= next_state;
			force_bit <= next_force_bit;
		end
	end

	// Override whenever shut, forced, or a raw source is live.
	// Outputs come from flops, so "immediate" costs one generator clock;
	// the sync delay of the sources is kept off this path.
	assign take_override = src_hit_raw || in_shut
		|| force_set_i || force_bit;          // [R04] [R01]

	// Next output levels and flags
	always_comb begin
		next_wave_prev = wave_sync;
		next_force_out = next_force_bit;
		next_active    = (next_state != was_pkg::WAS_RUN);
		if (take_override) begin
			next_wave_out = override_level_i; // [R04] [R01]
		end else begin
			next_wave_out = gen_out_i;
		end
	end

	// Register outputs and the edge detector history
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wave_prev            <= `WAS_WAVE_RST;
			wave_out_o           <= `WAS_OVR_RST;
			shutdown_force_bit_o <= `WAS_FORCE_RST;
			shutdown_active_o    <= `WAS_FLAG_RST;
		end else begin
			wave_prev            <= next_wave_prev;
			wave_out_o           <= next_wave_out;
			shutdown_force_bit_o <= next_force_out;
			shutdown_active_o    <= next_active;
		end
	end

	// Limitations worth knowing:
	// - A source that clears less than one clock before a restart edge
	//   may still be seen by the synced path and delay the restart until
	//   the next rising edge of the input wave.
	// - The restart edge is taken from the synchronised wave, so a pulse
	//   shorter than two generator clocks can be missed.
	// - Override levels are sampled every clock; changing them during a
	//   shutdown moves the outputs on the next edge.
endmodule : was_shutdown
`default_nettype wire

// ===== core/was_sync.sv
// Three-stage synchroniser with agreement filter for one pin level
`timescale 1ns/1ps
`default_nettype none
module was_sync (
	input  wire logic ref_clk_i,   // Generator clock
	input  wire logic rst_i,       // Async reset, active high
	input  wire logic async_i,     // Level from outside the clock domain
	output logic      level_o      // Filtered synchronous level
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic       next_level;

	// Stage one feeds stage two only; level moves when two and three agree
	always_comb begin
		next_stage = {stage[1:0], async_i};
		next_level = level_o;
		if (stage[1] == stage[2]) begin
			next_level = stage[2];
		end
	end

	// Register stages
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage   <= 3'h0;
			level_o <= 1'b0;
		end else begin
			stage   <= next_stage;
			level_o <= next_level;
		end
	end
endmodule : was_sync
`default_nettype wire

// ===== testbench/was_power_stage.sv
// Power stage model that reports faults back to the block
`timescale 1ns/1ps
`default_nettype none
module was_power_stage (
	input  wire logic [1:0] gate_i,  // Gate drive B/A
	input  wire logic       trip_i,  // Bench overcurrent
	output logic            fault_o  // Fault, high active
);
	// Held as a level; shoot-through also trips it
	assign fault_o = trip_i | (&gate_i);
endmodule : was_power_stage
`default_nettype wire

// ===== testbench/was_shutdown_chk.sv
// Assertions on the auto-shutdown block ports
`timescale 1ns/1ps
`default_nettype none
module was_shutdown_chk (
	input wire logic       ref_clk_i,
	input wire logic       rst_i,
	input wire logic       shutdown_enable_i,
	input wire logic       auto_restart_i,
	input wire logic       force_set_i,
	input wire logic       force_clr_i,
	input wire logic [3:0] source_select_i,
	input wire logic [1:0] override_level_i,
	input wire logic       comparator_one_async_out_i,
	input wire logic       comparator_two_async_out_i,
	input wire logic       logic_cell_two_out_i,
	input wire logic       fault_pin_input_i,
	input wire logic       wave_in_i,
	input wire logic [1:0] gen_out_i,
	input wire logic [1:0] wave_out_o,
	input wire logic       shutdown_force_bit_o,
	input wire logic       shutdown_active_o
);
	wire logic fb = shutdown_force_bit_o;
	wire logic act = shutdown_active_o;
	// Raw selected source, which overrides before any synchroniser
	wire logic hit = shutdown_enable_i && |(source_select_i & {
		fault_pin_input_i, logic_cell_two_out_i,
		comparator_two_async_out_i, comparator_one_async_out_i});
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence rise_ev;
		$rose(wave_in_i) && auto_restart_i && fb && !hit;
	endsequence
	force_enter_a: assert property (
		force_set_i |=> fb && act && wave_out_o == $past(override_level_i))
		else $error("force shutdown missing");
	force_hold_a: assert property (
		!auto_restart_i && fb && !force_clr_i |=> fb) else $error("force lost");
	auto_restart_a: assert property (
		rise_ev |-> ##[1:8] !fb) else $error("no auto restart");
	source_override_a: assert property (
		hit |=> wave_out_o == $past(override_level_i)) else $error("no override");
	normal_pass_a: assert property (
		!act && !fb && !hit && !force_set_i |=> wave_out_o == $past(gen_out_i))
		else $error("wrong normal output");
	level_hold_a: assert property (
		hit && act |=> act) else $error("shutdown released");
	sync_restart_a: assert property (
		$rose(wave_in_i) && fb && !force_clr_i |=> fb) else $error("early restart");
endmodule : was_shutdown_chk
bind was_shutdown was_shutdown_chk chk_i (.*);
`default_nettype wire

// ===== testbench/was_shutdown_tb.sv
// Self-checking testbench for the auto-shutdown block
`timescale 1ns/1ps
`default_nettype none
module was_shutdown_tb;
	logic ref_clk_i = 0, rst_i = 1, shutdown_enable_i = 0, auto_restart_i = 0;
	logic force_set_i = 0, force_clr_i = 0, wave_in_i = 0, fault_pin_input_i;
	logic [3:0] source_select_i = 4'h0, src = 4'h0;
	logic [1:0] override_level_i = 2'h2, gen_out_i = 2'h1, wave_out_o;
	logic shutdown_force_bit_o, shutdown_active_o;
	int mismatches = 0, compares = 0;
	wire logic comparator_one_async_out_i = src[0];
	wire logic comparator_two_async_out_i = src[1];
	wire logic logic_cell_two_out_i = src[2];
	was_shutdown dut (.*);
	was_power_stage ps (.gate_i(wave_out_o), .trip_i(src[3]),
		.fault_o(fault_pin_input_i));
	initial forever #4 ref_clk_i = ~ref_clk_i;
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : tick
	task automatic chk(input logic [1:0] e, input logic [1:0] g);
		compares++;
		if (e !== g) begin
			mismatches++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// Force, hold, clear, then auto-restart, then every source in turn
	initial begin
		tick(10);
		rst_i <= 0;
		tick(2);
		force_set_i <= 1;
		tick(1);
		force_set_i <= 0;
		#1 chk(override_level_i, wave_out_o);
		tick(6);
		#1 chk(2'h3, {shutdown_force_bit_o, shutdown_active_o});
		tick(1);
		force_clr_i <= 1;
		tick(1);
		force_clr_i <= 0;
		tick(3);
		#1 chk(gen_out_i, wave_out_o);
		tick(1);
		auto_restart_i <= 1;
		force_set_i <= 1;
		tick(1);
		force_set_i <= 0;
		tick(2);
		wave_in_i <= 1;
		tick(1);
		#1 chk(2'h1, {1'b0, shutdown_force_bit_o});
		for (int i = 0; i < 9 && shutdown_force_bit_o !== 1'b0; i++) begin
			tick(1);
			#1;
		end
		if (shutdown_force_bit_o !== 1'b0) begin
			mismatches++;
			$display("BAD t=%0t restart timed out", $time);
			tally_and_finish();
		end
		tick(2);
		#1 chk(gen_out_i, wave_out_o);
		tick(1);
		auto_restart_i <= 0;
		wave_in_i <= 0;
		for (int k = 0; k < 4; k++) begin
			tick(1);
			shutdown_enable_i <= 1;
			source_select_i <= ~(4'h1 << k);
			src <= 4'h1 << k;
			tick(4);
			#1 chk(gen_out_i, wave_out_o);
			tick(1);
			source_select_i <= 4'h1 << k;
			tick(1);
			#1 chk(override_level_i, wave_out_o);
			tick(1);
			force_clr_i <= 1;
			tick(1);
			force_clr_i <= 0;
			tick(4);
			#1 chk(2'h1, {1'b0, shutdown_active_o});
			tick(1);
			shutdown_enable_i <= 0;
			tick(3);
			#1 chk(gen_out_i, wave_out_o);
			tick(1);
			src <= 4'h0;
			tick(4);
		end
		tally_and_finish();
	end
endmodule : was_shutdown_tb
`default_nettype wire
